// *** bpc_bank_timer.sv ***
// per-bank delay timer for the device auto-close scheduling
`timescale 1ns/10ps
module bpc_bank_timer (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	input wire logic clk_en,
	// control
	input wire logic activate,
	input wire logic arm,
	input wire logic [bpc_pkg::CNT_W-1:0] delay,
	// status
	output logic fire
);
	import bpc_pkg::*;
	logic [CNT_W-1:0] ras_cnt;
	logic [CNT_W-1:0] dly_cnt;
	logic pending;
	logic [CNT_W-1:0] next_ras_cnt;
	logic [CNT_W-1:0] next_dly_cnt;
	logic next_pending;
	logic next_fire;
	always_comb begin
		next_ras_cnt = ras_cnt;
		next_dly_cnt = dly_cnt;
		next_pending = pending;
		next_fire = 1'b0;
		if (activate) begin
			next_ras_cnt = CNT_W'(N_RAS);
		end else if (ras_cnt != CNT_ZERO) begin
			next_ras_cnt = ras_cnt - 8'h01;
		end
		if (arm) begin
			next_pending = 1'b1;
			next_dly_cnt = delay;
		end else if (pending) begin
			if (dly_cnt != CNT_ZERO) begin
				next_dly_cnt = dly_cnt - 8'h01;
			end else if (ras_cnt <= 8'h01) begin
				next_pending = 1'b0;
				next_fire = 1'b1;
			end
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ras_cnt <= CNT_ZERO;
			dly_cnt <= CNT_ZERO;
			pending <= 1'b0;
			fire <= 1'b0;
		end else if (clk_en) begin
			ras_cnt <= next_ras_cnt;
			dly_cnt <= next_dly_cnt;
			pending <= next_pending;
			fire <= next_fire;
		end
	end
endmodule

// *** bpc_controller.sv ***
// controller end: issues two-cycle commands, enforces bank spacing
`timescale 1ns/10ps
module bpc_controller (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	input wire logic clk_en,
	// link
	bpc_link_if.ctrl link,
	// user request
	input wire logic req_valid,
	input wire bpc_pkg::bpc_cmd_t req_cmd,
	input wire logic [2:0] req_bank,
	input wire logic req_flag,
	input wire logic bl32_mode,
	input wire logic [1:0] scale_level,
	output logic req_ready
);
	import bpc_pkg::*;
	typedef enum {BPC_C_IDLE, BPC_C_SECOND} bpc_cstate_t;
	bpc_cstate_t state, next_state;
	logic [CNT_W-1:0] act_wait [NUM_BANKS];
	logic [CNT_W-1:0] pre_wait [NUM_BANKS];
	logic [CNT_W-1:0] next_act_wait [NUM_BANKS];
	logic [CNT_W-1:0] next_pre_wait [NUM_BANKS];
	logic next_cs;
	logic [5:0] next_ca;
	logic next_ready;
	logic cs_q;
	logic [5:0] ca_q;
	bpc_cmd_t cmd_q, next_cmd_q;
	logic [2:0] bank_q, next_bank_q;
	logic flag_q, next_flag_q;
	logic ok;
	assign link.cs = cs_q;
	assign link.ca = ca_q;
	function automatic logic [CNT_W-1:0] cmax(input logic [CNT_W-1:0] a,
		input logic [CNT_W-1:0] b);
		cmax = (a > b) ? a : b;
	endfunction
	always_comb begin
		logic [CNT_W-1:0] half, wr_n, rd_pre, wr_pre, ap_pre;
		half = bl32_mode ? CNT_W'(BL32 / 2) : CNT_W'(BL16 / 2);
		ap_pre = CNT_ZERO;
		wr_n = (scale_level == 2'h1) ? CNT_W'(N_WR1) : CNT_W'(N_WR0);
		rd_pre = cmax(half, (half - CNT_W'(BL32_EXTRA)) + CNT_W'(N_RTP));
		wr_pre = CNT_W'(WL + 1) + half + wr_n;
		next_state = state;
		next_cs = 1'b0;
		next_ca = 6'h00;
		next_cmd_q = cmd_q;
		next_bank_q = bank_q;
		next_flag_q = flag_q;
		for (int i = 0; i < NUM_BANKS; i++) begin
			next_act_wait[i] = (act_wait[i] != CNT_ZERO) ? act_wait[i] - 8'h01 : CNT_ZERO;
			next_pre_wait[i] = (pre_wait[i] != CNT_ZERO) ? pre_wait[i] - 8'h01 : CNT_ZERO;
		end
		ok = 1'b1;
		case (req_cmd)
			BPC_CMD_ACT: ok = (act_wait[req_bank] == CNT_ZERO);
			BPC_CMD_PRE: begin
				if (req_flag) begin
					for (int i = 0; i < NUM_BANKS; i++) begin
						ok = ok & (pre_wait[i] == CNT_ZERO);
					end
				end else begin
					ok = (pre_wait[req_bank] == CNT_ZERO);
				end
			end
			default: ok = 1'b1;
		endcase
		case (state)
			BPC_C_IDLE: begin
				if (req_valid && req_ready && ok) begin
					next_cs = 1'b1;
					next_ca = {req_flag, 2'h0, 3'(req_cmd)};
					next_cmd_q = req_cmd;
					next_bank_q = req_bank;
					next_flag_q = req_flag;
					next_state = BPC_C_SECOND;
				end
			end
			BPC_C_SECOND: begin
				next_ca = {3'h0, bank_q};
				next_state = BPC_C_IDLE;
				for (int i = 0; i < NUM_BANKS; i++) begin
					if (i[2:0] == bank_q || (cmd_q == BPC_CMD_PRE && flag_q)) begin
						case (cmd_q)
							BPC_CMD_ACT: begin
								next_act_wait[i] = CNT_W'(N_RC);
								next_pre_wait[i] = CNT_W'(N_RAS);
							end
							BPC_CMD_PRE: next_act_wait[i] = cmax(next_act_wait[i],
								flag_q ? CNT_W'(N_RPAB) : CNT_W'(N_RPPB));
							BPC_CMD_RD: begin
								next_pre_wait[i] = cmax(next_pre_wait[i], rd_pre);
								if (flag_q) begin
									ap_pre = rd_pre + CNT_W'(N_RPPB);
									next_act_wait[i] = cmax(next_act_wait[i], ap_pre);
								end
							end
							BPC_CMD_WR, BPC_CMD_MWR: begin
								next_pre_wait[i] = cmax(next_pre_wait[i], wr_pre);
								if (flag_q) begin
									ap_pre = wr_pre + CNT_W'(N_RPPB);
									next_act_wait[i] = cmax(next_act_wait[i], ap_pre);
								end
							end
							default: begin
							end
						endcase
					end
				end
			end
			default: next_state = BPC_C_IDLE;
		endcase
		// low for the two command cycles only; the registered ready keeps takes 3 apart
		next_ready = (state == BPC_C_IDLE) && !next_cs;
	end
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state <= BPC_C_IDLE;
			cs_q <= 1'b0;
			ca_q <= 6'h00;
			req_ready <= 1'b0;
			cmd_q <= BPC_CMD_NOP;
			bank_q <= 3'h0;
			flag_q <= 1'b0;
			for (int i = 0; i < NUM_BANKS; i++) begin
				act_wait[i] <= CNT_ZERO;
				pre_wait[i] <= CNT_ZERO;
			end
		end else if (clk_en) begin
			state <= next_state;
			cs_q <= next_cs;
			ca_q <= next_ca;
			req_ready <= next_ready;
			cmd_q <= next_cmd_q;
			bank_q <= next_bank_q;
			flag_q <= next_flag_q;
			for (int i = 0; i < NUM_BANKS; i++) begin
				act_wait[i] <= next_act_wait[i];
				pre_wait[i] <= next_pre_wait[i];
			end
		end
	end
endmodule

// *** bpc_device.sv ***
// device end: bank open state, precharge and auto-close scheduling
`timescale 1ns/10ps
module bpc_device (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	input wire logic clk_en,
	// link
	bpc_link_if.dev link,
	// configuration
	input wire logic bl32_mode,
	input wire logic [1:0] scale_level_in,
	// status
	output logic [bpc_pkg::NUM_BANKS-1:0] bank_open,
	output logic [1:0] scaling_mode_register,
	output logic auto_close_done,
	output logic array_write_start
);
	import bpc_pkg::*;
	typedef enum {BPC_D_FIRST, BPC_D_SECOND} bpc_dstate_t;
	bpc_dstate_t state, next_state;
	logic cs_s1, cs_s2;
	logic [5:0] ca_s1, ca_s2;
	bpc_cmd_t cmd_q, next_cmd_q;
	logic flag_q, next_flag_q;
	logic [NUM_BANKS-1:0] next_bank_open;
	logic [1:0] next_scale;
	logic [NUM_BANKS-1:0] act_vec;
	logic [NUM_BANKS-1:0] arm_vec;
	logic [NUM_BANKS-1:0] fire_vec;
	logic [CNT_W-1:0] arm_delay;
	logic [3:0] beat_cnt, next_beat_cnt;
	logic [5:0] burst_left, next_burst_left;
	logic next_done;
	logic next_aws;
	logic [2:0] bank_sel;
	logic [1:0] scale_s1;
	function automatic logic [NUM_BANKS-1:0] bank_onehot(input logic [2:0] b);
		bank_onehot = 8'h01 << b;
	endfunction
	function automatic logic is_write(input bpc_cmd_t c);
		is_write = (c == BPC_CMD_WR) || (c == BPC_CMD_MWR);
	endfunction
	// levels 2 and 3 are reserved and keep the default recovery
	function automatic logic [CNT_W-1:0] wr_recovery(input logic [1:0] level);
		if (level == 2'h1) begin
			wr_recovery = CNT_W'(N_WR1);
		end else begin
			wr_recovery = CNT_W'(N_WR0);
		end
	endfunction
	// scale level is a pin: the scaling register is its second stage
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			cs_s1 <= 1'b0;
			cs_s2 <= 1'b0;
			ca_s1 <= 6'h00;
			ca_s2 <= 6'h00;
			scale_s1 <= SCALE_RESET;
		end else if (clk_en) begin
			scale_s1 <= scale_level_in;
			cs_s1 <= link.cs;
			cs_s2 <= cs_s1;
			ca_s1 <= link.ca;
			ca_s2 <= ca_s1;
		end
	end
	assign bank_sel = ca_s2[BANK_LSB +: 3];
	// arm delay: read nRTP (+8 at BL32), write WL+BL/2+1+nWR
	always_comb begin
		logic [CNT_W-1:0] wr_n;
		wr_n = wr_recovery(scaling_mode_register);
		if (cmd_q == BPC_CMD_RD) begin
			arm_delay = bl32_mode ? CNT_W'(N_RTP + BL32_EXTRA) : CNT_W'(N_RTP);
		end else begin
			arm_delay = CNT_W'(WL + 1) + wr_n
				+ (bl32_mode ? CNT_W'(BL32 / 2) : CNT_W'(BL16 / 2));
		end
	end
	// command decode: first cycle latched, second cycle acted on
	always_comb begin
		next_state = state;
		next_cmd_q = cmd_q;
		next_flag_q = flag_q;
		case (state)
			BPC_D_FIRST: begin
				if (cs_s2) begin
					next_cmd_q = bpc_cmd_t'(ca_s2[CMD_LSB +: 3]);
					next_flag_q = ca_s2[FLAG_POS];
					next_state = BPC_D_SECOND;
				end
			end
			// the bank cycle always follows the command cycle directly
			BPC_D_SECOND: begin
				next_state = BPC_D_FIRST;
			end
			default: begin
				next_state = BPC_D_FIRST;
			end
		endcase
	end
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state <= BPC_D_FIRST;
			cmd_q <= BPC_CMD_NOP;
			flag_q <= 1'b0;
		end else if (clk_en) begin
			state <= next_state;
			cmd_q <= next_cmd_q;
			flag_q <= next_flag_q;
		end
	end
	// bank state: an activate in the same cycle as a fire wins
	always_comb begin
		act_vec = BANKS_RESET;
		arm_vec = BANKS_RESET;
		next_bank_open = bank_open & ~fire_vec;
		if (state == BPC_D_SECOND) begin
			case (cmd_q)
				BPC_CMD_ACT: begin
					act_vec = bank_onehot(bank_sel);
					next_bank_open = next_bank_open | bank_onehot(bank_sel);
				end
				BPC_CMD_PRE: begin
					if (flag_q) begin
						next_bank_open = BANKS_RESET;
					end else begin
						next_bank_open = next_bank_open & ~bank_onehot(bank_sel);
					end
				end
				BPC_CMD_RD, BPC_CMD_WR, BPC_CMD_MWR: begin
					if (flag_q) begin
						arm_vec = bank_onehot(bank_sel);
					end
				end
				default: begin
				end
			endcase
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			bank_open <= BANKS_RESET;
		end else if (clk_en) begin
			bank_open <= next_bank_open;
		end
	end
	always_comb begin
		next_burst_left = burst_left;
		next_beat_cnt = beat_cnt;
		next_aws = 1'b0;
		// two beats per clock; a group commits when its last pair lands
		if (burst_left != 6'h00) begin
			next_burst_left = burst_left - 6'h02;
			next_beat_cnt = beat_cnt + 4'h2;
			if (beat_cnt == 4'hE) begin
				next_aws = 1'b1;
			end
		end
		// a new write restarts the count at once, cutting off the rest of the old burst
		if (state == BPC_D_SECOND && is_write(cmd_q)) begin
			next_burst_left = bl32_mode ? 6'(BL32) : 6'(BL16);
			next_beat_cnt = 4'h0;
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			burst_left <= 6'h00;
			beat_cnt <= 4'h0;
			array_write_start <= 1'b0;
		end else if (clk_en) begin
			burst_left <= next_burst_left;
			beat_cnt <= next_beat_cnt;
			array_write_start <= next_aws;
		end
	end
	// status: reported scaling level and auto-close pulse
	always_comb begin
		next_scale = scale_s1;
		next_done = |fire_vec;
	end
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			scaling_mode_register <= SCALE_RESET;
			auto_close_done <= 1'b0;
		end else if (clk_en) begin
			scaling_mode_register <= next_scale;
			auto_close_done <= next_done;
		end
	end
	// one lockout timer per bank, so auto-closes on several banks overlap
	generate
		for (genvar i = 0; i < NUM_BANKS; i++) begin : g_bank
			bpc_bank_timer u_timer (
				.clk(clk),
				.rst_b(rst_b),
				.clk_en(clk_en),
				.activate(act_vec[i]),
				.arm(arm_vec[i]),
				.delay(arm_delay),
				.fire(fire_vec[i])
			);
		end
	endgenerate
endmodule

// *** bpc_link_if.sv ***
// command/address link between memory controller and device
`timescale 1ns/10ps
interface bpc_link_if;
	logic cs;
	logic [5:0] ca;
	modport ctrl (output cs, output ca);
	modport dev (input cs, input ca);
endinterface

// *** bpc_link_monitor.sv ***
// checker of command framing and bank spacing on the link
`timescale 1ns/10ps
module bpc_link_monitor (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// link
	input wire logic cs,
	input wire logic [5:0] ca
);
	import bpc_pkg::*;
	logic c2, next_c2, flag_q, next_flag_q, wr_auto, next_wr_auto;
	logic [2:0] cmd_q, next_cmd_q, rd_bank, next_rd_bank, wr_bank, next_wr_bank;
	logic [7:0] gap, next_gap, rd_age, next_rd_age, wr_age, next_wr_age;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// ages count from the first command cycle, saturating
	always_comb begin
		next_c2 = cs;
		next_cmd_q = cs ? ca[2:0] : cmd_q;
		next_flag_q = cs ? ca[5] : flag_q;
		next_gap = cs ? 8'h01 : ((gap == 8'hFF) ? gap : gap + 8'h01);
		next_rd_age = (rd_age == 8'hFF) ? rd_age : rd_age + 8'h01;
		next_wr_age = (wr_age == 8'hFF) ? wr_age : wr_age + 8'h01;
		next_rd_bank = rd_bank;
		next_wr_bank = wr_bank;
		next_wr_auto = wr_auto;
		if (c2 && cmd_q == BPC_CMD_RD) begin
			next_rd_age = 8'h02;
			next_rd_bank = ca[2:0];
		end
		if (c2 && (cmd_q == BPC_CMD_WR || cmd_q == BPC_CMD_MWR)) begin
			next_wr_age = 8'h02;
			next_wr_bank = ca[2:0];
			next_wr_auto = flag_q;
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			c2 <= 1'b0;
			cmd_q <= 3'h0;
			flag_q <= 1'b0;
			gap <= 8'hFF;
			rd_age <= 8'hFF;
			wr_age <= 8'hFF;
			rd_bank <= 3'h0;
			wr_bank <= 3'h0;
			wr_auto <= 1'b0;
		end else begin
			c2 <= next_c2;
			cmd_q <= next_cmd_q;
			flag_q <= next_flag_q;
			gap <= next_gap;
			rd_age <= next_rd_age;
			wr_age <= next_wr_age;
			rd_bank <= next_rd_bank;
			wr_bank <= next_wr_bank;
			wr_auto <= next_wr_auto;
		end
	end
	cs_single_a: assert property (cs |=> !cs ##1 !cs)
		else $error("command marker longer than one cycle");
	cmd_spacing_a: assert property (cs |-> gap >= 8'h03)
		else $error("commands closer than three cycles");
	cmd_code_a: assert property (cs |-> ca[2:0] inside {[3'h1:3'h5]} && ca[4:3] == 2'h0)
		else $error("bad first command cycle");
	bank_field_a: assert property (c2 |-> ca[5:3] == 3'h0)
		else $error("bad second command cycle");
	rd_pre_gap_a: assert property (c2 && cmd_q == BPC_CMD_PRE && (flag_q || ca[2:0] == rd_bank)
		|-> rd_age >= 8'(BL16 / 2 + 1))
		else $error("precharge too soon after read");
	wr_pre_gap_a: assert property (c2 && cmd_q == BPC_CMD_PRE && (flag_q || ca[2:0] == wr_bank)
		|-> wr_age >= 8'(WL + BL16 / 2 + 1 + N_WR0 + 1))
		else $error("precharge too soon after write");
	auto_wr_act_a: assert property (c2 && cmd_q == BPC_CMD_ACT && wr_auto && ca[2:0] == wr_bank
		|-> wr_age >= 8'(WL + BL16 / 2 + N_WR0 + N_RPPB + 2))
		else $error("activate too soon after auto-closing write");
	reset_idle_a: assert property (disable iff (1'b0) !rst_b |=> !cs && ca == 6'h00)
		else $error("link active in reset");
endmodule

// *** bpc_pkg.sv ***
// package for the bank precharge control channel: commands, timing, layouts
// Behaviour
// - precharge closes one bank or all banks
// - all-bank flag first cycle, bank second cycle
// - controller waits tRPab or tRPpb before activate
// - all-bank recovery longer, timed separately
// - read to precharge at least BL/2, tRAS
// - activate same bank only after tRP
// - tRTP counting starts BL/2 minus 8
// - read-to-precharge also covers analog minimum
// - write recovery tWR before precharging bank
// - array writes start at 16-beat boundaries
// - write to precharge WL+BL/2+1+tWR
// - scaling level 0 18ns, 1 34ns
// - device reports scaling level, controller adapts
// - auto-close flag precharges bank after burst
// - auto-close low leaves bank open
// - internal precharge delayed until tRAS met
// - controller waits tRC between activates
// - auto read precharge nRTP or 8+nRTP
// - after auto read wait tRP and tRC
// - auto write precharge tWR after burst
// - after auto write wait tRP and tRC
package bpc_pkg;
	localparam int CLK_PERIOD_PS = 50000;
	localparam int NUM_BANKS = 8;
	localparam int CA_W = 6;
	// command codes on ca[2:0] of the first cycle (block-local encoding)
	typedef enum logic [2:0] {
		BPC_CMD_NOP = 3'h0,
		BPC_CMD_ACT = 3'h1,
		BPC_CMD_PRE = 3'h2,
		BPC_CMD_RD = 3'h3,
		BPC_CMD_WR = 3'h4,
		BPC_CMD_MWR = 3'h5
	} bpc_cmd_t;
	localparam int CMD_LSB = 0;
	localparam int FLAG_POS = 5;
	localparam int BANK_LSB = 0;
	// times in ps as printed, then cycle counts rounded up
	localparam int T_RPAB_PS = 21000;
	localparam int T_RPPB_PS = 18000;
	localparam int T_RAS_PS = 42000;
	localparam int T_RC_PS = 63000;
	localparam int T_RTP_PS = 7500;
	localparam int T_WR0_PS = 18000;
	localparam int T_WR_SCALE_PS = 16000;
	localparam int T_WR1_PS = T_WR0_PS + T_WR_SCALE_PS;
	localparam int N_RPAB = (T_RPAB_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int N_RPPB = (T_RPPB_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int N_RAS = (T_RAS_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int N_RC = (T_RC_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int N_RTP = (T_RTP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int N_WR0 = (T_WR0_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int N_WR1 = (T_WR1_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int WL = 6;
	localparam int BL16 = 16;
	localparam int BL32 = 32;
	localparam int BL32_EXTRA = 8;
	localparam int PREFETCH = 16;
	localparam int CNT_W = 8;
	localparam logic [1:0] SCALE_RESET = 2'h0;
	localparam logic [NUM_BANKS-1:0] BANKS_RESET = 8'h00;
	localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
endpackage

// *** tb_bank_precharge_control.sv ***
// testbench: controller and device joined over the link
`timescale 1ns/10ps
module tb_bank_precharge_control;
	import bpc_pkg::*;
	logic clk, rst_b, clk_en, req_valid, req_flag, req_ready, bl32_mode, auto_done, aws;
	bpc_cmd_t req_cmd;
	logic [2:0] req_bank;
	logic [1:0] scale_level, scaling_mode_register;
	logic [7:0] bank_open;
	int err_total, samples_checked, aws_cnt;
	bpc_link_if bpc_link_if_inst ();
	bpc_controller bpc_controller_inst (.clk(clk), .rst_b(rst_b), .clk_en(clk_en),
		.link(bpc_link_if_inst), .req_valid(req_valid), .req_cmd(req_cmd), .req_bank(req_bank),
		.req_flag(req_flag), .bl32_mode(bl32_mode), .scale_level(scale_level),
		.req_ready(req_ready));
	bpc_device bpc_device_inst (.clk(clk), .rst_b(rst_b), .clk_en(clk_en),
		.link(bpc_link_if_inst), .bl32_mode(bl32_mode), .scale_level_in(scale_level),
		.bank_open(bank_open), .scaling_mode_register(scaling_mode_register),
		.auto_close_done(auto_done), .array_write_start(aws));
	bpc_link_monitor bpc_link_monitor_inst (.clk(clk), .rst_b(rst_b),
		.cs(bpc_link_if_inst.cs), .ca(bpc_link_if_inst.ca));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) begin
		if (aws === 1'b1) aws_cnt++;
	end
	task automatic test_done;
		if (err_total == 0 && samples_checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clk);
	endtask
	// hold the request until its first command cycle shows on the link
	task automatic issue(input bpc_cmd_t cmd, input logic [2:0] bank, input logic flag);
		@(posedge clk);
		req_valid <= 1'b1;
		req_cmd <= cmd;
		req_bank <= bank;
		req_flag <= flag;
		for (int i = 0; i < 60 && bpc_link_if_inst.cs !== 1'b1; i++) @(posedge clk);
		req_valid <= 1'b0;
	endtask
	task automatic auto_close(input bpc_cmd_t cmd, input logic [2:0] bank, input int d,
		input int writes);
		int n;
		issue(BPC_CMD_ACT, bank, 1'b0);
		aws_cnt = 0;
		issue(cmd, bank, 1'b1);
		n = 0;
		while (n < 90 && auto_done !== 1'b1) begin
			@(posedge clk);
			n++;
		end
		check("close_time", 8'h01, {7'h00, n >= d && n <= d + 7});
		idle(4);
		check("bank_closed", 8'h00, {7'h00, bank_open[bank]});
		check("array_writes", 8'(writes), 8'(aws_cnt));
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		test_done;
	end
	initial begin
		rst_b = 1'b0;
		clk_en = 1'b1;
		req_valid = 1'b0;
		req_cmd = BPC_CMD_NOP;
		req_bank = 3'h0;
		req_flag = 1'b0;
		bl32_mode = 1'b0;
		scale_level = 2'h0;
		err_total = 0;
		samples_checked = 0;
		aws_cnt = 0;
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		idle(3);
		check("bank_open", 8'h00, bank_open);
		check("scaling", 8'h00, {6'h00, scaling_mode_register});
		check("req_ready", 8'h01, {7'h00, req_ready});
		for (int b = 0; b < NUM_BANKS; b++) issue(BPC_CMD_ACT, 3'(b), 1'b0);
		idle(6);
		check("bank_open", 8'hFF, bank_open);
		for (int b = 0; b < NUM_BANKS; b++) begin
			issue(BPC_CMD_PRE, 3'(b), 1'b0);
			idle(6);
			check("bank_open", 8'hFF << (b + 1), bank_open);
		end
		issue(BPC_CMD_ACT, 3'h1, 1'b0);
		check("req_ready", 8'h00, {7'h00, req_ready});
		issue(BPC_CMD_ACT, 3'h4, 1'b0);
		issue(BPC_CMD_PRE, 3'h5, 1'b1);
		idle(6);
		check("bank_open", 8'h00, bank_open);
		issue(BPC_CMD_ACT, 3'h5, 1'b0);
		issue(BPC_CMD_RD, 3'h5, 1'b0);
		idle(30);
		check("bank_open", 8'h20, bank_open);
		issue(BPC_CMD_PRE, 3'h5, 1'b0);
		aws_cnt = 0;
		issue(BPC_CMD_ACT, 3'h5, 1'b0);
		issue(BPC_CMD_WR, 3'h5, 1'b0);
		idle(30);
		check("bank_open", 8'h20, bank_open);
		check("array_writes", 8'(BL16 / PREFETCH), 8'(aws_cnt));
		issue(BPC_CMD_PRE, 3'h5, 1'b0);
		auto_close(BPC_CMD_RD, 3'h2, N_RTP, 0);
		auto_close(BPC_CMD_WR, 3'h6, WL + 1 + BL16 / 2 + N_WR0, BL16 / PREFETCH);
		issue(BPC_CMD_ACT, 3'h6, 1'b0);
		idle(6);
		check("bank_open", 8'h40, bank_open);
		issue(BPC_CMD_PRE, 3'h6, 1'b0);
		auto_close(BPC_CMD_MWR, 3'h7, WL + 1 + BL16 / 2 + N_WR0, BL16 / PREFETCH);
		bl32_mode <= 1'b1;
		auto_close(BPC_CMD_RD, 3'h2, BL32_EXTRA + N_RTP, 0);
		auto_close(BPC_CMD_WR, 3'h6, WL + 1 + BL32 / 2 + N_WR0, BL32 / PREFETCH);
		scale_level <= 2'h1;
		idle(3);
		check("scaling", 8'h01, {6'h00, scaling_mode_register});
		auto_close(BPC_CMD_WR, 3'h3, WL + 1 + BL32 / 2 + N_WR1, BL32 / PREFETCH);
		issue(BPC_CMD_ACT, 3'h0, 1'b0);
		rst_b <= 1'b0;
		idle(12);
		rst_b <= 1'b1;
		idle(3);
		check("bank_open", 8'h00, bank_open);
		test_done;
	end
endmodule
